/* File: logic/appc_defs.svh */
/*
  Constants for the audio port pad pull control block: register indices,
  byte addresses, field positions and reset values.
  Assumes it is included by bare name by every file that needs a number.
*/
`ifndef APPC_DEFS_SVH
`define APPC_DEFS_SVH

`define APPC_IDX_PORT1    12'hC23
`define APPC_IDX_PORT2    12'hC24
`define APPC_IDX_PORT3    12'hC25
`define APPC_IDX_FLOAT    12'hC26
`define APPC_BYTE_ADDR(i) ({2'b00, (i), 2'b00})

`define APPC_FRAME_PU     5
`define APPC_FRAME_PD     4
`define APPC_BCLK_PU      3
`define APPC_BCLK_PD      2
`define APPC_RX_PU        1
`define APPC_RX_PD        0

`define APPC_PULL_W       6
`define APPC_PULL_RESET   6'h00
`define APPC_FLOAT_RESET  3'h0
`define APPC_NPORTS       3
`define APPC_NPINS        3
`define APPC_NPADS        9

`endif

/* File: logic/appc_pad_if.sv */
/*
  Per-pad signal bundle between the control top, the pad keeper and the
  pad driver.
  Assumes one instance per audio port pin, all in the pclk domain.
*/
`timescale 1ns/1ps
interface appc_pad_if;
    logic pu_bit;
    logic pd_bit;
    logic float_en;
    logic core_drive;
    logic core_level;
    logic pin_in;
    logic pullup_en;
    logic pulldown_en;
    logic keeper_en;
    logic keeper_level;
    logic pin_out;
    logic pin_oe_n;

    modport ctrl (output pu_bit, pd_bit, float_en, core_drive, core_level, pin_in,
                  input pullup_en, pulldown_en, keeper_en, keeper_level, pin_out, pin_oe_n);
    modport keeper (input pu_bit, pd_bit, pin_in,
                    output pullup_en, pulldown_en, keeper_en, keeper_level);
    modport driver (input float_en, core_drive, core_level,
                    output pin_out, pin_oe_n);
endinterface

/* File: logic/appc_pad_pull_ctrl.sv */
/*
  Top of the audio port pad pull control: APB register file and nine pads.
  Assumes an APB master on pclk and pad cells that resolve the wire level
  from the pull, keeper and drive signals and return it on pin_in.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "appc_defs.svh"

// Overview of operation
// - Frame clock, bit clock and receive data pins each get pull-up and pull-down.
// - Each pull has its own bit; 1 enables, 0 disables; reset disables all.
// - Both bits set on one pin enables a keeper instead of two pulls.
// - Active keeper holds the pin at its last level while nobody drives it.
// - Bit 5 enables frame clock pull-up, bit 4 frame clock pull-down.
// - Bit 3 enables bit clock pull-up, bit 2 bit clock pull-down.
// - Bit 1 enables receive data pull-up, bit 0 receive data pull-down.
// - Port float control releases that port's output pins, leaving pulls or keeper.
module appc_pad_pull_ctrl
    import appc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire appc_pkg::appc_pinvec_t p1_core_drive,
    input  wire appc_pkg::appc_pinvec_t p1_core_level,
    input  wire appc_pkg::appc_pinvec_t p1_pin_in,
    output appc_pkg::appc_pinvec_t   p1_pin_out,
    output appc_pkg::appc_pinvec_t   p1_pin_oe_n,
    input  wire appc_pkg::appc_pinvec_t p2_core_drive,
    input  wire appc_pkg::appc_pinvec_t p2_core_level,
    input  wire appc_pkg::appc_pinvec_t p2_pin_in,
    output appc_pkg::appc_pinvec_t   p2_pin_out,
    output appc_pkg::appc_pinvec_t   p2_pin_oe_n,
    input  wire appc_pkg::appc_pinvec_t p3_core_drive,
    input  wire appc_pkg::appc_pinvec_t p3_core_level,
    input  wire appc_pkg::appc_pinvec_t p3_pin_in,
    output appc_pkg::appc_pinvec_t   p3_pin_out,
    output appc_pkg::appc_pinvec_t   p3_pin_oe_n,
    output logic                     p1_frame_clock_pullup_en,
    output logic                     p1_frame_clock_pulldown_en,
    output logic                     p1_bit_clock_pullup_en,
    output logic                     p1_bit_clock_pulldown_en,
    output logic                     p1_rx_data_pullup_en,
    output logic                     p1_rx_data_pulldown_en,
    output logic                     p2_frame_clock_pullup_en,
    output logic                     p2_frame_clock_pulldown_en,
    output logic                     p2_bit_clock_pullup_en,
    output logic                     p2_bit_clock_pulldown_en,
    output logic                     p2_rx_data_pullup_en,
    output logic                     p2_rx_data_pulldown_en,
    output logic                     p3_frame_clock_pullup_en,
    output logic                     p3_frame_clock_pulldown_en,
    output logic                     p3_bit_clock_pullup_en,
    output logic                     p3_bit_clock_pulldown_en,
    output logic                     p3_rx_data_pullup_en,
    output logic                     p3_rx_data_pulldown_en,
    output appc_pkg::appc_pinvec_t   p1_keeper_en,
    output appc_pkg::appc_pinvec_t   p1_keeper_level,
    output appc_pkg::appc_pinvec_t   p2_keeper_en,
    output appc_pkg::appc_pinvec_t   p2_keeper_level,
    output appc_pkg::appc_pinvec_t   p3_keeper_en,
    output appc_pkg::appc_pinvec_t   p3_keeper_level
);
    import appc_pkg::*;

    appc_pull_t   pull_ctrl      [0:`APPC_NPORTS-1];
    appc_pull_t   next_pull_ctrl [0:`APPC_NPORTS-1];
    appc_pinvec_t float_ctrl;
    appc_pinvec_t next_float_ctrl;
    logic [31:0]  next_prdata;
    logic         next_pslverr;
    logic         setup_phase;
    logic         access_phase;
    appc_sel_t    sel;

    appc_pinvec_t drive_a  [0:`APPC_NPORTS-1];
    appc_pinvec_t level_a  [0:`APPC_NPORTS-1];
    appc_pinvec_t in_a     [0:`APPC_NPORTS-1];
    appc_pinvec_t out_a    [0:`APPC_NPORTS-1];
    appc_pinvec_t oe_n_a   [0:`APPC_NPORTS-1];
    appc_pinvec_t pu_a     [0:`APPC_NPORTS-1];
    appc_pinvec_t pd_a     [0:`APPC_NPORTS-1];
    appc_pinvec_t keep_a   [0:`APPC_NPORTS-1];
    appc_pinvec_t klevel_a [0:`APPC_NPORTS-1];

    appc_pad_if pad [0:`APPC_NPADS-1] ();

    // Only exact word addresses hit; everything else errors
    function automatic appc_sel_t decode_sel(input logic [15:0] a);
        case (a)
            `APPC_BYTE_ADDR(`APPC_IDX_PORT1): decode_sel = APPC_SEL_PORT1;
            `APPC_BYTE_ADDR(`APPC_IDX_PORT2): decode_sel = APPC_SEL_PORT2;
            `APPC_BYTE_ADDR(`APPC_IDX_PORT3): decode_sel = APPC_SEL_PORT3;
            `APPC_BYTE_ADDR(`APPC_IDX_FLOAT): decode_sel = APPC_SEL_FLOAT;
            default:                          decode_sel = APPC_SEL_NONE;
        endcase
    endfunction

    function automatic int pull_pos(input int pin, input logic up);
        case (appc_pin_t'(pin[1:0]))
            APPC_PIN_FRAME: pull_pos = up ? `APPC_FRAME_PU : `APPC_FRAME_PD;
            APPC_PIN_BCLK:  pull_pos = up ? `APPC_BCLK_PU  : `APPC_BCLK_PD;
            APPC_PIN_RX:    pull_pos = up ? `APPC_RX_PU    : `APPC_RX_PD;
            default:        pull_pos = up ? `APPC_RX_PU    : `APPC_RX_PD;
        endcase
    endfunction

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign sel          = decode_sel(paddr);
    // Read data was captured in setup, so no wait state is needed
    assign pready       = access_phase;

    always_comb begin
        next_pull_ctrl  = pull_ctrl;
        next_float_ctrl = float_ctrl;
        next_prdata     = prdata;
        next_pslverr    = pslverr;
        if (setup_phase) begin
            next_pslverr = (sel == APPC_SEL_NONE);
            next_prdata  = 32'h00000000;
            if (!pwrite) begin
                case (sel)
                    APPC_SEL_PORT1: next_prdata = {26'h0, pull_ctrl[0]};
                    APPC_SEL_PORT2: next_prdata = {26'h0, pull_ctrl[1]};
                    APPC_SEL_PORT3: next_prdata = {26'h0, pull_ctrl[2]};
                    APPC_SEL_FLOAT: next_prdata = {29'h0, float_ctrl};
                    default:        next_prdata = 32'h00000000;
                endcase
            end
        end
        // Used bits all sit in byte lane 0
        if (access_phase && pwrite && pstrb[0]) begin
            case (sel)
                APPC_SEL_PORT1: next_pull_ctrl[0] = pwdata[`APPC_PULL_W-1:0];
                APPC_SEL_PORT2: next_pull_ctrl[1] = pwdata[`APPC_PULL_W-1:0];
                APPC_SEL_PORT3: next_pull_ctrl[2] = pwdata[`APPC_PULL_W-1:0];
                APPC_SEL_FLOAT: next_float_ctrl   = pwdata[`APPC_NPORTS-1:0];
                default:        next_float_ctrl   = float_ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < `APPC_NPORTS; n++) begin
                pull_ctrl[n] <= `APPC_PULL_RESET;
            end
            float_ctrl <= `APPC_FLOAT_RESET;
            prdata     <= 32'h00000000;
            pslverr    <= 1'b0;
        end else begin
            pull_ctrl  <= next_pull_ctrl;
            float_ctrl <= next_float_ctrl;
            prdata     <= next_prdata;
            pslverr    <= next_pslverr;
        end
    end

    assign drive_a[0] = p1_core_drive;
    assign drive_a[1] = p2_core_drive;
    assign drive_a[2] = p3_core_drive;
    assign level_a[0] = p1_core_level;
    assign level_a[1] = p2_core_level;
    assign level_a[2] = p3_core_level;
    assign in_a[0]    = p1_pin_in;
    assign in_a[1]    = p2_pin_in;
    assign in_a[2]    = p3_pin_in;

    for (genvar g = 0; g < `APPC_NPORTS; g++) begin : g_port
        for (genvar k = 0; k < `APPC_NPINS; k++) begin : g_pin
            localparam int IDX = g * `APPC_NPINS + k;
            assign pad[IDX].pu_bit     = pull_ctrl[g][pull_pos(k, 1'b1)];
            assign pad[IDX].pd_bit     = pull_ctrl[g][pull_pos(k, 1'b0)];
            assign pad[IDX].float_en   = float_ctrl[g];
            assign pad[IDX].core_drive = drive_a[g][k];
            assign pad[IDX].core_level = level_a[g][k];
            assign pad[IDX].pin_in     = in_a[g][k];
            assign pu_a[g][k]          = pad[IDX].pullup_en;
            assign pd_a[g][k]          = pad[IDX].pulldown_en;
            assign keep_a[g][k]        = pad[IDX].keeper_en;
            assign klevel_a[g][k]      = pad[IDX].keeper_level;
            assign out_a[g][k]         = pad[IDX].pin_out;
            assign oe_n_a[g][k]        = pad[IDX].pin_oe_n;

            appc_pin_keeper u_keeper (
                .pclk    (pclk),
                .presetn (presetn),
                .pad     (pad[IDX])
            );
            appc_pin_driver u_driver (
                .pclk    (pclk),
                .presetn (presetn),
                .pad     (pad[IDX])
            );
        end
    end

    assign p1_pin_out      = out_a[0];
    assign p2_pin_out      = out_a[1];
    assign p3_pin_out      = out_a[2];
    assign p1_pin_oe_n     = oe_n_a[0];
    assign p2_pin_oe_n     = oe_n_a[1];
    assign p3_pin_oe_n     = oe_n_a[2];
    assign p1_keeper_en    = keep_a[0];
    assign p2_keeper_en    = keep_a[1];
    assign p3_keeper_en    = keep_a[2];
    assign p1_keeper_level = klevel_a[0];
    assign p2_keeper_level = klevel_a[1];
    assign p3_keeper_level = klevel_a[2];

    assign p1_frame_clock_pullup_en   = pu_a[0][APPC_PIN_FRAME];
    assign p1_frame_clock_pulldown_en = pd_a[0][APPC_PIN_FRAME];
    assign p1_bit_clock_pullup_en     = pu_a[0][APPC_PIN_BCLK];
    assign p1_bit_clock_pulldown_en   = pd_a[0][APPC_PIN_BCLK];
    assign p1_rx_data_pullup_en       = pu_a[0][APPC_PIN_RX];
    assign p1_rx_data_pulldown_en     = pd_a[0][APPC_PIN_RX];
    assign p2_frame_clock_pullup_en   = pu_a[1][APPC_PIN_FRAME];
    assign p2_frame_clock_pulldown_en = pd_a[1][APPC_PIN_FRAME];
    assign p2_bit_clock_pullup_en     = pu_a[1][APPC_PIN_BCLK];
    assign p2_bit_clock_pulldown_en   = pd_a[1][APPC_PIN_BCLK];
    assign p2_rx_data_pullup_en       = pu_a[1][APPC_PIN_RX];
    assign p2_rx_data_pulldown_en     = pd_a[1][APPC_PIN_RX];
    assign p3_frame_clock_pullup_en   = pu_a[2][APPC_PIN_FRAME];
    assign p3_frame_clock_pulldown_en = pd_a[2][APPC_PIN_FRAME];
    assign p3_bit_clock_pullup_en     = pu_a[2][APPC_PIN_BCLK];
    assign p3_bit_clock_pulldown_en   = pd_a[2][APPC_PIN_BCLK];
    assign p3_rx_data_pullup_en       = pu_a[2][APPC_PIN_RX];
    assign p3_rx_data_pulldown_en     = pd_a[2][APPC_PIN_RX];

    // Pad enables follow the register bits one edge after the write
    chk_frame_write: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && pstrb[0] && sel == APPC_SEL_PORT1 |=>
        p1_frame_clock_pullup_en == ($past(pwdata[`APPC_FRAME_PU]) && !$past(pwdata[`APPC_FRAME_PD])))
        else $error("frame clock pull-up not from bit 5");

    chk_bclk_write: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && pstrb[0] && sel == APPC_SEL_PORT2 |=>
        p2_bit_clock_pulldown_en == ($past(pwdata[`APPC_BCLK_PD]) && !$past(pwdata[`APPC_BCLK_PU])))
        else $error("bit clock pull-down not from bit 2");

    chk_rx_write: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && pstrb[0] && sel == APPC_SEL_PORT3 |=>
        p3_keeper_en[APPC_PIN_RX] == ($past(pwdata[`APPC_RX_PU]) && $past(pwdata[`APPC_RX_PD])))
        else $error("receive data keeper not from bits 1 and 0");

    chk_hold_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        !(access_phase && pwrite) |=> $stable(p1_rx_data_pullup_en) && $stable(p2_frame_clock_pullup_en))
        else $error("pull enable changed without a write");

    // Lane zero carries every used bit, so its strobe gates the write
    chk_strobe_off: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && !pstrb[0] |=> $stable(pull_ctrl[0]) && $stable(float_ctrl))
        else $error("write without lane zero strobe landed");

    // Read data is the register as it stood at the setup edge
    chk_read_port: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && sel == APPC_SEL_PORT1 |=> prdata == {26'h0, $past(pull_ctrl[0])})
        else $error("port one read data wrong");

    chk_read_float: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && sel == APPC_SEL_FLOAT |=> prdata == {29'h0, $past(float_ctrl)})
        else $error("float control read data wrong");

    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && sel == APPC_SEL_NONE |=> pready && pslverr)
        else $error("unmapped access not flagged");

    chk_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && sel == APPC_SEL_NONE |=> prdata == 32'h0)
        else $error("unmapped access returned data");

    // Release and drive must follow the float bit without a lag
    chk_float_port: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && pstrb[0] && sel == APPC_SEL_FLOAT && pwdata[0] |=> p1_pin_oe_n == 3'h7)
        else $error("port one outputs not released");

    chk_float_follow: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && pstrb[0] && sel == APPC_SEL_FLOAT && !pwdata[1] |=>
        p2_pin_oe_n == ~p2_core_drive)
        else $error("port two outputs not driven after float clear");

    // Main scenarios the bench should reach
    cov_keeper_on: cover property (@(posedge pclk) disable iff (!presetn) p1_keeper_en[APPC_PIN_FRAME]);

    cov_float_keep: cover property (@(posedge pclk) disable iff (!presetn) float_ctrl[1] && p2_keeper_en != 3'h0);

    cov_err_access: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

    cov_strobe_skip: cover property (@(posedge pclk) disable iff (!presetn) access_phase && pwrite && !pstrb[0]);

    cov_write_read: cover property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite ##1 setup_phase && !pwrite ##1 access_phase);
endmodule

/* File: logic/appc_pin_driver.sv */
/*
  Output stage of one pad: drive or release under the port float control.
  Assumes the core drive request and level are synchronous to pclk.
*/
`timescale 1ns/1ps
module appc_pin_driver (
    input wire logic    pclk,
    input wire logic    presetn,
    appc_pad_if.driver  pad
);
    // Active low enable; float wins over any core drive request
    assign pad.pin_oe_n = ~(pad.core_drive & ~pad.float_en);
    assign pad.pin_out  = pad.core_level;

    chk_float_release: assert property (@(posedge pclk) disable iff (!presetn)
        pad.float_en |-> pad.pin_oe_n)
        else $error("pad driven while port floated");
    chk_drive_pass: assert property (@(posedge pclk) disable iff (!presetn)
        !pad.float_en && pad.core_drive |-> !pad.pin_oe_n && pad.pin_out == pad.core_level)
        else $error("pad not driven on request");
endmodule

/* File: logic/appc_pin_keeper.sv */
/*
  Pull and keeper decode for one pad, plus the last-level holder.
  Assumes pin_in is the resolved pad level, synchronous to pclk.
*/
`timescale 1ns/1ps
module appc_pin_keeper (
    input wire logic    pclk,
    input wire logic    presetn,
    appc_pad_if.keeper  pad
);
    logic keeper_level;
    logic next_keeper_level;

    // Both bits set means keeper, never two opposing pulls
    assign pad.pullup_en   = pad.pu_bit & ~pad.pd_bit;
    assign pad.pulldown_en = pad.pd_bit & ~pad.pu_bit;
    assign pad.keeper_en   = pad.pu_bit & pad.pd_bit;

    // Tracks always so the held level is ready the moment drivers let go
    always_comb begin
        next_keeper_level = pad.pin_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keeper_level <= 1'b0;
        end else begin
            keeper_level <= next_keeper_level;
        end
    end

    assign pad.keeper_level = keeper_level;

    chk_keeper_pair: assert property (@(posedge pclk) disable iff (!presetn)
        pad.keeper_en == (pad.pu_bit && pad.pd_bit))
        else $error("keeper enable does not match pull bits");
    chk_pull_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !(pad.pullup_en && pad.pulldown_en) && !(pad.keeper_en && (pad.pullup_en || pad.pulldown_en)))
        else $error("opposing pulls enabled together");
    chk_keeper_holds: assert property (@(posedge pclk) disable iff (!presetn)
        pad.keeper_en && $stable(pad.pin_in) |=> pad.keeper_level == $past(pad.pin_in))
        else $error("keeper lost the last level");
endmodule

/* File: logic/appc_pkg.sv */
/*
  Types shared by the audio port pad pull control modules.
  Assumes appc_defs.svh holds the numbers.
*/
package appc_pkg;

    typedef logic [5:0] appc_pull_t;
    typedef logic [2:0] appc_pinvec_t;

    typedef enum logic [1:0] {
        APPC_PIN_RX    = 2'b00,
        APPC_PIN_BCLK  = 2'b01,
        APPC_PIN_FRAME = 2'b10
    } appc_pin_t;

    typedef enum logic [2:0] {
        APPC_SEL_NONE  = 3'b000,
        APPC_SEL_PORT1 = 3'b001,
        APPC_SEL_PORT2 = 3'b010,
        APPC_SEL_PORT3 = 3'b011,
        APPC_SEL_FLOAT = 3'b100
    } appc_sel_t;

endpackage

/* File: tb/appc_far_side.sv */
/*
  Far-side model: other audio devices on the nine port pins, plus wire resolution.
  Assumes pin vectors ordered port3..port1, each {frame clock, bit clock, rx data}.
*/
`timescale 1ns/1ps
module appc_far_side (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [8:0] dev_oe_n,
    input  wire logic [8:0] dev_level,
    input  wire logic [8:0] pull_up,
    input  wire logic [8:0] pull_down,
    input  wire logic [8:0] keep_en,
    input  wire logic [8:0] keep_level,
    input  wire logic [8:0] ext_drive,
    input  wire logic [8:0] ext_level,
    output logic      [8:0] pin_level
);
    logic [8:0] last_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_level <= 9'h000;
        end else begin
            last_level <= pin_level;
        end
    end

    // Floating wire wanders each cycle, so a stale level never passes as held
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            if (!dev_oe_n[i]) begin
                pin_level[i] = dev_level[i];
            end else if (ext_drive[i]) begin
                pin_level[i] = ext_level[i];
            end else if (pull_up[i]) begin
                pin_level[i] = 1'b1;
            end else if (pull_down[i]) begin
                pin_level[i] = 1'b0;
            end else if (keep_en[i]) begin
                pin_level[i] = keep_level[i];
            end else begin
                pin_level[i] = ~last_level[i];
            end
        end
    end
endmodule

/* File: tb/audio_port_pad_pull_control_bench.sv */
/*
  Self-checking bench for the audio port pad pull control, with a register model.
  Assumes an APB slave that may stretch the access and the far-side model beside it.
*/
`timescale 1ns/1ps
`include "appc_defs.svh"
module audio_port_pad_pull_control_bench;
    import appc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr;
    logic [8:0]  core_drive, core_level, ext_drive, ext_level;
    wire  [8:0]  pin_in, oe_n, pin_out, keep_en, keep_lvl, pu, pd;
    logic [5:0]  pull_m [3];
    logic [2:0]  float_m;
    logic [15:0] addr_tab [5];
    logic [2:0]  lvl;
    int          n_mismatch, checks_done, cycles;

    appc_pad_pull_ctrl dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .p1_core_drive(core_drive[2:0]), .p1_core_level(core_level[2:0]), .p1_pin_in(pin_in[2:0]),
        .p1_pin_out(pin_out[2:0]), .p1_pin_oe_n(oe_n[2:0]),
        .p2_core_drive(core_drive[5:3]), .p2_core_level(core_level[5:3]), .p2_pin_in(pin_in[5:3]),
        .p2_pin_out(pin_out[5:3]), .p2_pin_oe_n(oe_n[5:3]),
        .p3_core_drive(core_drive[8:6]), .p3_core_level(core_level[8:6]), .p3_pin_in(pin_in[8:6]),
        .p3_pin_out(pin_out[8:6]), .p3_pin_oe_n(oe_n[8:6]),
        .p1_frame_clock_pullup_en(pu[2]), .p1_frame_clock_pulldown_en(pd[2]),
        .p1_bit_clock_pullup_en(pu[1]), .p1_bit_clock_pulldown_en(pd[1]),
        .p1_rx_data_pullup_en(pu[0]), .p1_rx_data_pulldown_en(pd[0]),
        .p2_frame_clock_pullup_en(pu[5]), .p2_frame_clock_pulldown_en(pd[5]),
        .p2_bit_clock_pullup_en(pu[4]), .p2_bit_clock_pulldown_en(pd[4]),
        .p2_rx_data_pullup_en(pu[3]), .p2_rx_data_pulldown_en(pd[3]),
        .p3_frame_clock_pullup_en(pu[8]), .p3_frame_clock_pulldown_en(pd[8]),
        .p3_bit_clock_pullup_en(pu[7]), .p3_bit_clock_pulldown_en(pd[7]),
        .p3_rx_data_pullup_en(pu[6]), .p3_rx_data_pulldown_en(pd[6]),
        .p1_keeper_en(keep_en[2:0]), .p1_keeper_level(keep_lvl[2:0]),
        .p2_keeper_en(keep_en[5:3]), .p2_keeper_level(keep_lvl[5:3]),
        .p3_keeper_en(keep_en[8:6]), .p3_keeper_level(keep_lvl[8:6])
    );

    appc_far_side far_u (
        .pclk(pclk), .presetn(presetn), .dev_oe_n(oe_n), .dev_level(pin_out), .pull_up(pu),
        .pull_down(pd), .keep_en(keep_en), .keep_level(keep_lvl), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_level(pin_in)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk_pads();
        logic [8:0] eu, ed, ek, eo;
        for (int i = 0; i < 9; i++) begin
            eu[i] = pull_m[i/3][2*(i%3)+1] & ~pull_m[i/3][2*(i%3)];
            ed[i] = pull_m[i/3][2*(i%3)] & ~pull_m[i/3][2*(i%3)+1];
            ek[i] = pull_m[i/3][2*(i%3)] & pull_m[i/3][2*(i%3)+1];
            eo[i] = ~(core_drive[i] & ~float_m[i/3]);
        end
        chk(32'(pu), 32'(eu));
        chk(32'(pd), 32'(ed));
        chk(32'(keep_en), 32'(ek));
        chk(32'(oe_n), 32'(eo));
        chk(32'(pin_out), 32'(core_level));
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, input logic e_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, s, rd, er);
        chk(32'(er), 32'(e_err));
        for (int p = 0; p < 3; p++) begin
            if (s[0] && a == addr_tab[p]) pull_m[p] = d[5:0];
        end
        if (s[0] && a == addr_tab[3]) float_m = d[2:0];
        @(negedge pclk);
        chk_pads();
        @(posedge pclk);
    endtask

    task automatic rd_chk(input int i);
        logic [31:0] rd, exp;
        logic        er;
        exp = (i < 3) ? {26'h0, pull_m[i]} : (i == 3) ? {29'h0, float_m} : 32'h0;
        apb(1'b0, addr_tab[i], 32'h0, 4'h0, rd, er);
        chk(rd, exp);
        chk(32'(er), 32'(i == 4));
        @(posedge pclk);
    endtask

    task automatic clear_model();
        pull_m = '{default: 6'h00};
        float_m = 3'h0;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {core_drive, core_level, ext_drive, ext_level} = '0;
        addr_tab = '{`APPC_BYTE_ADDR(`APPC_IDX_PORT1), `APPC_BYTE_ADDR(`APPC_IDX_PORT2),
                     `APPC_BYTE_ADDR(`APPC_IDX_PORT3), `APPC_BYTE_ADDR(`APPC_IDX_FLOAT), 16'h309C};
        clear_model();
        cycles = $urandom(38);
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) rd_chk(i);
        // Every single bit, then both of each pair, on every port
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 9; b++) wr(addr_tab[p], (b < 6) ? (32'h1 << b) : (32'h3 << (2 * (b - 6))), 4'hF, 1'b0);
        end
        for (int k = 0; k < 40; k++) begin
            core_drive <= 9'($urandom);
            core_level <= 9'($urandom);
            lvl = 3'($urandom_range(0, 4));
            wr(addr_tab[lvl], $urandom, 4'($urandom), lvl == 3'd4);
            rd_chk(int'(lvl));
        end
        // Keeper must hold what the far side last drove once everyone lets go
        for (int p = 0; p < 3; p++) begin
            wr(addr_tab[p], 32'h3F, 4'hF, 1'b0);
            wr(addr_tab[3], 32'h1 << p, 4'hF, 1'b0);
            lvl = 3'($urandom);
            ext_drive[3*p +: 3] <= 3'b111;
            ext_level[3*p +: 3] <= lvl;
            repeat (3) @(posedge pclk);
            ext_drive[3*p +: 3] <= 3'b000;
            ext_level[3*p +: 3] <= ~lvl;
            repeat (6) @(posedge pclk);
            @(negedge pclk);
            chk(32'(keep_lvl[3*p +: 3]), 32'(lvl));
            chk(32'(pin_in[3*p +: 3]), 32'(lvl));
            chk_pads();
            @(posedge pclk);
            wr(addr_tab[3], 32'h0, 4'hF, 1'b0);
        end
        // Reset in mid-run clears everything again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        clear_model();
        @(negedge pclk);
        chk_pads();
        chk(32'(keep_lvl), 32'h0);
        @(posedge pclk);
        for (int i = 0; i < 5; i++) rd_chk(i);
        close_out();
    end
endmodule
